// ---- hw/cbx_pkg.sv ----
// shared constants and types for the byte-op and branch execution block
package cbx_pkg;
    localparam int INSTR_W = 14;
    localparam int DATA_W = 8;
    localparam int FADDR_W = 7;
    localparam int PC_W = 15;
    localparam int BR_W = 11;
    localparam int LIT_W = 8;
    // instruction and address latch field positions
    localparam int DEST_BIT = 7;
    localparam int OPC_HI = 13;
    localparam int OPC_LO = 8;
    localparam int LATCH_HI = 6;
    localparam int LATCH_LO = 3;
    // instruction encodings
    localparam logic [5:0] OPC_DEC_FILE = 6'h03;
    localparam logic [5:0] OPC_DEC_SKIP = 6'h0B;
    localparam logic [5:0] OPC_INC_SKIP = 6'h0F;
    localparam logic [5:0] OPC_OR_LIT = 6'h38;
    localparam logic [11:0] OPC_CLEAR_ACC = 12'h040;
    localparam logic [2:0] OPC_BRANCH = 3'h5;
    // reset values and the unit step
    localparam logic [DATA_W-1:0] W_RESET = 8'h00;
    localparam logic Z_RESET = 1'b0;
    localparam logic [PC_W-1:0] PC_RESET = 15'h0000;
    localparam logic [DATA_W-1:0] ONE = 8'h01;

    typedef enum logic [2:0] {ALU_NONE, ALU_DEC, ALU_INC, ALU_CLR, ALU_OR} cbx_alu_op_type;
    typedef enum logic [0:0] {ST_RUN, ST_SECOND} cbx_state_type;
endpackage : cbx_pkg

// ---- hw/cbx_alu_if.sv ----
// operand and result bundle between the executer and its arithmetic unit
`timescale 1ns/1ps
interface cbx_alu_if;
    import cbx_pkg::*;
    cbx_alu_op_type op;
    logic [DATA_W-1:0] a;
    logic [DATA_W-1:0] b;
    logic [DATA_W-1:0] result;
    logic zero;
    modport core (output op, output a, output b, input result, input zero);
    modport alu (input op, input a, input b, output result, output zero);
endinterface : cbx_alu_if

// ---- hw/cbx_alu.sv ----
// combinational arithmetic unit for the byte operations
`timescale 1ns/1ps
module cbx_alu
    import cbx_pkg::*;
(
    cbx_alu_if.alu bus
);
    wire [DATA_W-1:0] dec_res = bus.a - ONE;
    wire [DATA_W-1:0] inc_res = bus.a + ONE;
    wire [DATA_W-1:0] or_res = bus.a | bus.b;

    assign bus.result = (bus.op == ALU_DEC) ? dec_res :
                        (bus.op == ALU_INC) ? inc_res :
                        (bus.op == ALU_OR) ? or_res :
                        (bus.op == ALU_CLR) ? W_RESET : bus.a;
    // zero judged on the full 8-bit result
    assign bus.zero = (bus.result == W_RESET);
endmodule : cbx_alu

// ---- hw/cbx_exec.sv ----
// execution unit for decrement, clear, skip, branch and or-literal operations
`timescale 1ns/1ps
module cbx_exec
    import cbx_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic instr_valid_i,
    input wire logic [INSTR_W-1:0] instr_i,
    input wire logic [DATA_W-1:0] file_data_i,
    input wire logic [DATA_W-1:0] upper_address_latch_i,
    output logic instr_ready_o,
    output logic [DATA_W-1:0] w_o,
    output logic zero_o,
    output logic file_we_o,
    output logic [FADDR_W-1:0] file_addr_o,
    output logic [DATA_W-1:0] file_wdata_o,
    output logic pc_load_o,
    output logic [PC_W-1:0] pc_o,
    output logic flush_o
);
    ////////////////////////////////////////////////////////////////////////////
    cbx_alu_if alu_bus ();
    cbx_alu u_alu (.bus(alu_bus.alu));

    cbx_state_type state;
    cbx_state_type next_state;

    ////////////////////////////////////////////////////////////////////////////
    // decode
    wire [5:0] opc = instr_i[OPC_HI:OPC_LO];
    wire is_dec = (opc == OPC_DEC_FILE);
    wire is_dsz = (opc == OPC_DEC_SKIP);
    wire is_isz = (opc == OPC_INC_SKIP);
    wire is_or = (opc == OPC_OR_LIT);
    wire is_clear = (instr_i[OPC_HI:2] == OPC_CLEAR_ACC);
    wire is_branch = (instr_i[OPC_HI:BR_W] == OPC_BRANCH);
    wire to_file = instr_i[DEST_BIT];
    wire file_op = is_dec | is_dsz | is_isz;
    // second cycle of a two-cycle op is the flushed slot, so nothing is taken then
    wire take = instr_valid_i & instr_ready_o;

    assign alu_bus.op = (is_dec | is_dsz) ? ALU_DEC :
                        is_isz ? ALU_INC :
                        is_or ? ALU_OR :
                        is_clear ? ALU_CLR : ALU_NONE;
    assign alu_bus.a = is_or ? w_o : file_data_i;
    assign alu_bus.b = instr_i[LIT_W-1:0];

    wire write_w = take & ((file_op & ~to_file) | is_clear | is_or);
    wire write_f = take & file_op & to_file;
    // skip ops leave the zero flag alone
    wire write_z = take & (is_dec | is_clear | is_or);
    wire skip = take & (is_dsz | is_isz) & alu_bus.zero;
    wire branch = take & is_branch;
    wire [PC_W-1:0] branch_pc = {upper_address_latch_i[LATCH_HI:LATCH_LO],
                                 instr_i[BR_W-1:0]};
    wire next_z = is_clear ? 1'b1 : alu_bus.zero;

    assign next_state = (state == ST_RUN && (skip || branch)) ? ST_SECOND : ST_RUN;

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            state <= ST_RUN;
            instr_ready_o <= 1'b0;
        end else begin
            state <= next_state;
            instr_ready_o <= (next_state == ST_RUN);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            w_o <= W_RESET;
            zero_o <= Z_RESET;
        end else begin
            if (write_w) begin
                w_o <= alu_bus.result;
            end
            if (write_z) begin
                zero_o <= next_z;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            file_we_o <= 1'b0;
            file_addr_o <= '0;
            file_wdata_o <= W_RESET;
        end else begin
            file_we_o <= write_f;
            if (write_f) begin
                file_addr_o <= instr_i[FADDR_W-1:0];
                file_wdata_o <= alu_bus.result;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            pc_load_o <= 1'b0;
            pc_o <= PC_RESET;
            flush_o <= 1'b0;
        end else begin
            pc_load_o <= branch;
            flush_o <= skip | branch;
            if (branch) begin
                pc_o <= branch_pc;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    sequence second_slot_s;
        flush_o && !instr_ready_o && $stable(zero_o) ##1 instr_ready_o;
    endsequence

    dec_to_w_a: assert property (take && is_dec && !to_file |=>
        w_o == DATA_W'($past(file_data_i) - ONE) && !file_we_o)
        else $error("decrement to accumulator wrong");
    dec_to_file_a: assert property (take && is_dec && to_file |=>
        file_we_o && file_wdata_o == DATA_W'($past(file_data_i) - ONE)
        && $stable(w_o))
        else $error("decrement to file wrong");
    // the literal sits where the destination bit would be, so it is not a qualifier here
    zero_follows_a: assert property (take && ((is_dec && !to_file) || is_or) |=>
        zero_o == (w_o == W_RESET))
        else $error("zero flag does not match result");
    clear_sets_a: assert property (take && is_clear |=>
        w_o == W_RESET && zero_o)
        else $error("clear accumulator wrong");
    dsz_skip_a: assert property (take && is_dsz && file_data_i == ONE |=>
        second_slot_s)
        else $error("decrement skip did not take two cycles");
    isz_skip_a: assert property (take && is_isz && file_data_i == 8'hFF |=>
        second_slot_s)
        else $error("increment skip did not take two cycles");
    isz_noskip_a: assert property (take && is_isz && file_data_i != 8'hFF |=>
        !flush_o && instr_ready_o && $stable(zero_o))
        else $error("increment skipped on nonzero result");
    branch_pc_a: assert property (take && is_branch |=> pc_load_o &&
        pc_o[BR_W-1:0] == $past(instr_i[BR_W-1:0]) &&
        pc_o[PC_W-1:BR_W] == $past(upper_address_latch_i[LATCH_HI:LATCH_LO]))
        else $error("branch target wrong");
    branch_two_a: assert property (take && is_branch |=> second_slot_s)
        else $error("branch not two cycles");
    or_lit_a: assert property (take && is_or |=>
        w_o == ($past(w_o) | $past(alu_bus.b)))
        else $error("or literal result wrong");

    ////////////////////////////////////////////////////////////////////////////
    // zero flag of the plain decrement, judged on the file operand
    dec_zero_a: assert property (take && is_dec |=>
        zero_o == ($past(file_data_i) == ONE))
        else $error("decrement zero flag wrong");
    dec_quiet_a: assert property (take && is_dec |=>
        !flush_o && instr_ready_o)
        else $error("decrement stalled the stream");
    file_addr_a: assert property (take && file_op && to_file |=>
        file_addr_o == $past(instr_i[FADDR_W-1:0]))
        else $error("file write address wrong");

    // skip ops store like the plain ones but never touch the flag
    dsz_noskip_a: assert property (take && is_dsz && file_data_i != ONE |=>
        !flush_o && instr_ready_o && $stable(zero_o))
        else $error("decrement skipped on nonzero result");
    dsz_to_w_a: assert property (take && is_dsz && !to_file |=>
        w_o == DATA_W'($past(file_data_i) - ONE) && !file_we_o)
        else $error("decrement skip to accumulator wrong");
    dsz_to_file_a: assert property (take && is_dsz && to_file |=>
        file_we_o && file_wdata_o == DATA_W'($past(file_data_i) - ONE) && $stable(w_o))
        else $error("decrement skip to file wrong");
    isz_to_w_a: assert property (take && is_isz && !to_file |=>
        w_o == DATA_W'($past(file_data_i) + ONE) && !file_we_o)
        else $error("increment skip to accumulator wrong");
    isz_to_file_a: assert property (take && is_isz && to_file |=>
        file_we_o && file_wdata_o == DATA_W'($past(file_data_i) + ONE) && $stable(w_o))
        else $error("increment skip to file wrong");
    // a word offered in the flushed slot must leave no trace
    slot_ignored_a: assert property (!instr_ready_o |=>
        $stable(w_o) && $stable(zero_o) && !file_we_o && !pc_load_o)
        else $error("word taken in flushed slot");

    // the branch only steers the program counter
    branch_keeps_a: assert property (take && is_branch |=>
        $stable(zero_o) && $stable(w_o) && !file_we_o)
        else $error("branch altered state");
    load_pulse_a: assert property (pc_load_o |=> !pc_load_o)
        else $error("program counter load held too long");
    flush_ends_a: assert property (flush_o |=> !flush_o && instr_ready_o)
        else $error("flushed slot longer than one cycle");

    // single-cycle ops keep the stream flowing
    clear_quiet_a: assert property (take && is_clear |=>
        !file_we_o && !flush_o && instr_ready_o)
        else $error("clear accumulator side effect");
    or_quiet_a: assert property (take && is_or |=>
        !file_we_o && !flush_o && instr_ready_o)
        else $error("or literal side effect");
    or_zero_a: assert property (take && is_or |=>
        zero_o == (w_o == W_RESET))
        else $error("or literal zero flag wrong");
endmodule : cbx_exec

// ---- verification/cpu_byte_op_branch_exec_tb_top.sv ----
// self-checking bench for the byte-op and branch execution block
`timescale 1ns/1ps
module cpu_byte_op_branch_exec_tb_top import cbx_pkg::*; ();
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic instr_valid_i = 1'b0;
    logic [INSTR_W-1:0] instr_i = '0;
    logic [DATA_W-1:0] file_data_i = 8'h00;
    logic [DATA_W-1:0] latch = 8'h00;
    logic rdy, zf, we, pl, fl;
    logic [DATA_W-1:0] w, wd;
    logic [FADDR_W-1:0] fa;
    logic [PC_W-1:0] pc;
    int checks = 0;
    int miscompares = 0;
    int cycles = 0;

    cbx_exec i_dut (.clk_i(clk_i), .rstn_i(rstn_i), .instr_valid_i(instr_valid_i),
        .instr_i(instr_i), .file_data_i(file_data_i), .upper_address_latch_i(latch),
        .instr_ready_o(rdy), .w_o(w), .zero_o(zf), .file_we_o(we), .file_addr_o(fa),
        .file_wdata_o(wd), .pc_load_o(pl), .pc_o(pc), .flush_o(fl));

    initial begin
        forever #2 clk_i = ~clk_i;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("wrong value at %0t ns: %s", $time, msg);
        end
    endtask : chk

    // drives on the falling edge, returns one falling edge after the taking edge
    task automatic issue(input logic [INSTR_W-1:0] ins, input logic [DATA_W-1:0] fd);
        @(negedge clk_i);
        instr_valid_i = 1'b1;
        instr_i = ins;
        file_data_i = fd;
        @(negedge clk_i);
        instr_valid_i = 1'b0;
    endtask : issue
    ////////////////////////////////////////////////////////////////////////
    task automatic t_decrement();
        issue({OPC_DEC_FILE, 1'b0, 7'h05}, 8'h05);
        chk(w === 8'h04 && zf === 1'b0 && we === 1'b0, "decrement to acc");
        issue({OPC_DEC_FILE, 1'b1, 7'h7F}, 8'h01);
        chk(we === 1'b1 && fa === 7'h7F && wd === 8'h00 && zf === 1'b1 && w === 8'h04,
            "decrement to file");
        @(negedge clk_i);
        chk(we === 1'b0 && fa === 7'h7F && wd === 8'h00, "file write pulse");
    endtask : t_decrement

    task automatic t_literal();
        issue({OPC_OR_LIT, 8'h80}, 8'h00);
        chk(w === 8'h84 && zf === 1'b0, "or literal");
        issue({OPC_CLEAR_ACC, 2'b00}, 8'h5A);
        chk(w === 8'h00 && zf === 1'b1, "clear acc");
        issue({OPC_OR_LIT, 8'h00}, 8'h00);
        chk(w === 8'h00 && zf === 1'b1, "or zero literal");
        issue({OPC_OR_LIT, 8'h81}, 8'h00);
        chk(w === 8'h81 && zf === 1'b0, "or literal again");
    endtask : t_literal

    // a word offered during the flushed slot must be ignored
    task automatic skip_case(input logic [5:0] opc, input logic d, input logic [7:0] fd,
                             input logic [7:0] res);
        logic zk;
        logic [DATA_W-1:0] wk;
        zk = zf;
        wk = w;
        issue({opc, d, 7'h2A}, fd);
        chk((d ? (we === 1'b1 && fa === 7'h2A && wd === res && w === wk)
               : (w === res && we === 1'b0)) && zf === zk, "skip op store");
        chk(fl === (res == 8'h00) && rdy === (res != 8'h00), "skip slot");
        if (res == 8'h00) begin
            instr_valid_i = 1'b1;
            instr_i = {OPC_OR_LIT, 8'hFF};
            @(negedge clk_i);
            instr_valid_i = 1'b0;
            chk(w !== 8'hFF && fl === 1'b0 && rdy === 1'b1 && zf === zk, "nop slot");
        end
    endtask : skip_case

    task automatic t_skip();
        skip_case(OPC_DEC_SKIP, 1'b0, 8'h01, 8'h00);
        skip_case(OPC_DEC_SKIP, 1'b1, 8'h03, 8'h02);
        skip_case(OPC_INC_SKIP, 1'b1, 8'hFF, 8'h00);
        skip_case(OPC_INC_SKIP, 1'b0, 8'h10, 8'h11);
    endtask : t_skip

    task automatic t_branch(input logic [7:0] lt, input logic [10:0] k, input logic [14:0] tgt);
        logic zk;
        zk = zf;
        latch = lt;
        issue({OPC_BRANCH, k}, 8'h00);
        chk(pl === 1'b1 && pc === tgt && fl === 1'b1 && rdy === 1'b0 && zf === zk,
            "branch target");
        @(negedge clk_i);
        chk(pl === 1'b0 && fl === 1'b0 && rdy === 1'b1 && pc === tgt, "branch end");
    endtask : t_branch
    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk_i) begin
        cycles++;
        // run needs under a hundred cycles
        if (cycles == 1000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (16) @(negedge clk_i);
        chk(rdy === 1'b0 && w === 8'h00 && zf === 1'b0 && pc === 15'h0000, "reset values");
        rstn_i = 1'b1;
        @(negedge clk_i);
        t_decrement();
        t_literal();
        t_skip();
        t_branch(8'h58, 11'h7FF, 15'h5FFF);
        t_branch(8'h87, 11'h001, 15'h0001);
        tally_and_finish();
    end
endmodule : cpu_byte_op_branch_exec_tb_top
